// ### rtl/gpc_pkg.sv
// Package with constants for the port-change GPIO block
package gpc_pkg;
  localparam int          GPC_WIDTH      = 8;
  localparam int          GPC_CHG_LO     = 4;
  localparam int          GPC_ANA_PINS   = 5;
  localparam int          GPC_ALT_PIN    = 3;
  localparam logic [7:0]  GPC_LAT_RST    = 8'h00;
  localparam logic [7:0]  GPC_DIR_RST    = 8'hFF;
  localparam logic [7:0]  GPC_ANA_ON     = 8'h1F;
  localparam logic [7:0]  GPC_ANA_OFF    = 8'h00;
  localparam logic [7:0]  GPC_CHG_MASK   = 8'hF0;
  localparam logic        GPC_PU_DIS_RST = 1'b1;
endpackage : gpc_pkg

// ### rtl/gpc_change_det.sv
// Change detector comparing upper input pins with the snapshot taken at the last port read or ordinary (non-memory-move) port write
`timescale 1ns/100ps
module gpc_change_det
  import gpc_pkg::*;
#(
  parameter int WIDTH = GPC_WIDTH
)(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_level,
  input  wire logic [WIDTH-1:0] port_direction,
  input  wire logic             snap_strobe,
  output logic                  mismatch
);
  logic [WIDTH-1:0] snap_reg;
  logic [WIDTH-1:0] cmp_mask;

  // Snapshot refreshed on each qualifying port access
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      snap_reg <= GPC_LAT_RST;
    else if (snap_strobe)
      snap_reg <= pin_level;
  end

  // Only upper pins that are inputs take part
  assign cmp_mask = GPC_CHG_MASK[WIDTH-1:0] & port_direction;
  // Live compare, so a pin returning to its old value ends mismatch
  assign mismatch = |((pin_level ^ snap_reg) & cmp_mask);
endmodule : gpc_change_det

// ### rtl/gpc_port.sv
// Eight-bit bidirectional port with pull-ups and change flag
`timescale 1ns/100ps
module gpc_port
  import gpc_pkg::*;
#(
  parameter int WIDTH = GPC_WIDTH
)(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             port_analog_default_cfg,
  input  wire logic             capture_alt_pin_select,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_pullup_en,
  input  wire logic             port_rd,
  input  wire logic             port_wr,
  input  wire logic             port_wr_by_move,
  input  wire logic [WIDTH-1:0] port_wdata,
  output logic      [WIDTH-1:0] port_rdata,
  input  wire logic             latch_wr,
  input  wire logic [WIDTH-1:0] latch_wdata,
  output logic      [WIDTH-1:0] port_output_latch,
  input  wire logic             dir_wr,
  input  wire logic [WIDTH-1:0] dir_wdata,
  output logic      [WIDTH-1:0] port_direction,
  input  wire logic             analog_wr,
  input  wire logic [WIDTH-1:0] analog_wdata,
  output logic      [WIDTH-1:0] analog_sel,
  input  wire logic             pullup_wr,
  input  wire logic             pullup_wdata,
  output logic                  pullup_disable_n,
  input  wire logic             flag_clr,
  output logic                  port_change_flag,
  output logic                  wake_req,
  input  wire logic             capture_unit_out,
  input  wire logic             capture_unit_oe,
  output logic                  capture_unit_in,
  output logic                  capture_on_pin_three
);
  logic             por_seen_reg;
  logic             snap_strobe;
  logic             mismatch;
  logic             alt_route;
  logic [WIDTH-1:0] alt_mask;

  // Alternate routing of the capture/compare unit onto pin three
  assign alt_route         = ~capture_alt_pin_select;
  assign capture_on_pin_three = alt_route;
  assign alt_mask          = alt_route
                             ? (WIDTH'(1) << GPC_ALT_PIN) : '0;
  assign capture_unit_in   = pin_in[GPC_ALT_PIN];

  // Output latch, written through port or latch address
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      port_output_latch <= GPC_LAT_RST;
    else if (latch_wr)
      port_output_latch <= latch_wdata;
    else if (port_wr || port_wr_by_move)
      port_output_latch <= port_wdata;
  end

  // Direction register, all inputs after reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      port_direction <= GPC_DIR_RST;
    else if (dir_wr)
      port_direction <= dir_wdata;
  end

  // First cycle after reset flags that the strap must be sampled
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      por_seen_reg <= 1'b0;
    else
      por_seen_reg <= 1'b1;
  end

  // Analog select; strap taken in the first clocked cycle after reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      analog_sel <= GPC_ANA_ON[WIDTH-1:0];
    else if (!por_seen_reg)
      analog_sel <= port_analog_default_cfg
                    ? GPC_ANA_ON[WIDTH-1:0]
                    : GPC_ANA_OFF[WIDTH-1:0];
    else if (analog_wr)
      analog_sel <= analog_wdata;
  end

  // Global active-low pull-up control, disabled at reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pullup_disable_n <= GPC_PU_DIS_RST;
    else if (pullup_wr)
      pullup_disable_n <= pullup_wdata;
  end

  // Pin drivers: outputs drive latch, inputs are high impedance; pin three is driven by the capture unit when routed and enabled
  always_comb
  begin
    pin_oe  = ~port_direction;
    pin_out = port_output_latch;
    if (alt_route && capture_unit_oe)
    begin
      pin_oe  = pin_oe | alt_mask;
      pin_out = (pin_out & ~alt_mask) | (capture_unit_out ? alt_mask : '0);
    end
  end

  // Pull-ups on input pins only, gated by the global control
  assign pin_pullup_en = pullup_disable_n ? '0
                         : (port_direction & ~pin_oe);

  // Port read returns pin levels; analog pins read zero
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      port_rdata <= '0;
    else if (port_rd)
      port_rdata <= pin_in & ~analog_sel;
  end

  // Memory-move write to the port does not refresh the snapshot
  assign snap_strobe = port_rd || port_wr;

  gpc_change_det #(
    .WIDTH          (WIDTH)
  ) u_det (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .pin_level      (pin_in & ~analog_sel),
    .port_direction (port_direction),
    .snap_strobe    (snap_strobe),
    .mismatch       (mismatch)
  );

  // Change flag: mismatch sets, set wins over software clear
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      port_change_flag <= 1'b0;
    else if (mismatch)
      port_change_flag <= 1'b1;
    else if (flag_clr)
      port_change_flag <= 1'b0;
  end

  // Wake request for sleep and all idle modes
  assign wake_req = port_change_flag;
endmodule : gpc_port

// ### test/gpc_port_monitor.sv
// Checker of pin drive, pull-up and change-flag behaviour
`timescale 1ns/100ps
module gpc_port_monitor (
  input wire logic       ref_clk, sys_rst, capture_alt_pin_select, port_rd,
  input wire logic       port_wr, latch_wr, flag_clr, pullup_disable_n,
  input wire logic       port_change_flag, wake_req, capture_on_pin_three,
  input wire logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en,
  input wire logic [7:0] port_wdata, port_rdata, port_output_latch,
  input wire logic [7:0] port_direction, analog_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Driver state and driven level follow direction and latch
  oe_dir_a: assert property ((pin_oe & 8'hF7) == (~port_direction & 8'hF7))
    else $error("oe");
  out_latch_a: assert property (((pin_out ^ port_output_latch)
    & ~port_direction & 8'hF7) == 8'h00) else $error("out");
  // Pull-ups only on inputs, all together
  pu_off_a: assert property ((pin_pullup_en & ~port_direction) == 8'h00)
    else $error("pu out");
  pu_all_a: assert property (!pullup_disable_n |-> (pin_pullup_en & 8'hF7)
    == (port_direction & 8'hF7)) else $error("pu on");
  pu_dis_a: assert property (pullup_disable_n |-> pin_pullup_en == 8'h00)
    else $error("pu off");
  // Port access results
  rd_pins_a: assert property (port_rd |=> port_rdata ==
    ($past(pin_in) & ~$past(analog_sel))) else $error("rd");
  wr_latch_a: assert property (port_wr && !latch_wr |=>
    port_output_latch == $past(port_wdata)) else $error("wr");
  // Flag holds until cleared, wakes, alternate pin
  flag_hold_a: assert property (port_change_flag && !flag_clr |=>
    port_change_flag) else $error("flag");
  wake_flag_a: assert property (wake_req == port_change_flag)
    else $error("wake");
  alt_pin_a: assert property (capture_on_pin_three == !capture_alt_pin_select)
    else $error("alt");
endmodule : gpc_port_monitor
bind gpc_port gpc_port_monitor u_mon (.*);

// ### test/gpc_pins_model.sv
// Board model: external drivers, pull-ups and floating pins
`timescale 1ns/100ps
module gpc_pins_model (
  input wire logic       ref_clk,
  input wire logic [7:0] pin_out, pin_oe, pin_pullup_en, ext_val, ext_drv,
  output logic     [7:0] pin_in
);
  logic [7:0] flt_reg = 8'h55;
  // Undriven pin without pull-up wanders every cycle
  always @(posedge ref_clk) flt_reg <= ~flt_reg;
  // Device driver wins, then board, then pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
    | (~pin_oe & ~ext_drv & (pin_pullup_en | flt_reg));
endmodule : gpc_pins_model

// ### test/gpc_port_tb_top.sv
// Bench for the port: board model, reference values and checks
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module gpc_port_tb_top;
  import gpc_pkg::*;
  logic       ref_clk = 0, sys_rst = 1, cfg = 1, sel = 1, flag, wake, pun, on3;
  logic [7:0] st = 0, d = 0, ev = 0, ed = 8'hFF, pout, oe, pen, pin, rdata;
  logic [7:0] lat, dir, ana, m_lat, m_dir, m_ana;
  logic       m_pu, cap_o = 0, cap_oe = 0, cin;
  int         fails = 0, cmp_count = 0, cyc_n = 0;
  always #2.5 ref_clk = ~ref_clk;
  gpc_port u_dut (.ref_clk, .sys_rst, .port_analog_default_cfg(cfg),
    .capture_alt_pin_select(sel), .pin_in(pin), .pin_out(pout), .pin_oe(oe),
    .pin_pullup_en(pen), .port_rd(st[0]), .port_wr(st[1]),
    .port_wr_by_move(st[2]), .port_wdata(d), .port_rdata(rdata),
    .latch_wr(st[3]), .latch_wdata(d), .port_output_latch(lat),
    .dir_wr(st[4]), .dir_wdata(d), .port_direction(dir), .analog_wr(st[7]),
    .analog_wdata(d), .analog_sel(ana), .pullup_wr(st[5]),
    .pullup_wdata(d[0]), .pullup_disable_n(pun), .flag_clr(st[6]),
    .port_change_flag(flag), .wake_req(wake), .capture_unit_out(cap_o),
    .capture_unit_oe(cap_oe), .capture_unit_in(cin),
    .capture_on_pin_three(on3));
  gpc_pins_model u_pins (.ref_clk, .pin_out(pout), .pin_oe(oe),
    .pin_pullup_en(pen), .ext_val(ev), .ext_drv(ed), .pin_in(pin));
  task automatic report_and_stop(int extra);
    fails += extra;
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Cycle limit against a hang
  always @(posedge ref_clk) if (++cyc_n > 3000) report_and_stop(1);
  // Register outputs against the reference
  task automatic chk;
    `CHK("latch", m_lat, lat)
    `CHK("dir", m_dir, dir)
    `CHK("oe", ~m_dir, oe)
    `CHK("out", m_lat & ~m_dir, pout & ~m_dir)
    `CHK("pullup", m_dir & {8{~m_pu}}, pen)
    `CHK("analog", m_ana, ana)
  endtask : chk
  // One-cycle strobe with data, mirrored in the reference
  task automatic op(int k, logic [7:0] v);
    d = v;
    st = 8'h01 << k;
    @(negedge ref_clk);
    st = 0;
    case (k)
      1, 2, 3: m_lat = v;
      4: m_dir = v;
      5: m_pu = v[0];
      7: m_ana = v;
    endcase
    chk();
  endtask : op
  task automatic rd;
    op(0, 0);
    `CHK("rd", ((m_lat & ~m_dir) | (ev & m_dir)) & ~m_ana, rdata)
  endtask : rd
  task automatic rst(logic c);
    sys_rst = 1;
    cfg = c;
    repeat (2) @(negedge ref_clk);
    sys_rst = 0;
    repeat (2) @(negedge ref_clk);
    {m_lat, m_dir, m_pu} = {8'h00, 8'hFF, 1'b1};
    m_ana = c ? 8'h1F : 8'h00;
    chk();
    `CHK("pu", 1'b1, pun)
  endtask : rst
  task automatic wt(int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  // Main sequence
  initial
  begin
    void'($urandom(2));
    ev = 8'($urandom);
    rst(1);
    rd();
    rst(0);
    rd();
    op(3, 8'($urandom));
    op(1, ~ev);
    op(4, 8'h0F);
    rd();
    op(5, 0);
    ed = 8'hFE;
    op(0, 0);
    `CHK("pulled", 1'b1, rdata[0])
    ed = 8'hFF;
    op(4, 8'hDF);
    rd();
    op(6, 0);
    `CHK("idle", 1'b0, flag)
    ev[3] = ~ev[3];
    op(3, ~m_lat);
    wt(2);
    `CHK("excl", 1'b0, flag)
    ev[7] = ~ev[7];
    wt(2);
    `CHK("set", 1'b1, flag)
    `CHK("wake", 1'b1, wake)
    op(6, 0);
    op(2, m_lat);
    op(6, 0);
    `CHK("kept", 1'b1, flag)
    rd();
    op(6, 0);
    `CHK("clr", 1'b0, flag)
    ev[6] = ~ev[6];
    wt(1);
    ev[6] = ~ev[6];
    op(6, 0);
    wt(2);
    `CHK("ret", 1'b0, flag)
    op(7, 8'h1F);
    rd();
    sel = 0;
    cap_oe = 1;
    cap_o = 1;
    wt(1);
    `CHK("alt", 1'b1, on3)
    `CHK("cap oe", 1'b1, oe[3])
    `CHK("cap in", 1'b1, cin)
    report_and_stop(0);
  end
endmodule : gpc_port_tb_top
